// ---- rtl/dma_controller_status_view.sv ----
// top: activity status register and a 64-channel per-channel register set with shadow access
// assumes: activity inputs come from same-clock controller logic; reads answer next cycle
//
// Contract
// - the completion count field shows how many completion requests are outstanding, 0 to 63.
// - bit 4 is the OR of every other activity bit.
// - the active bit stays high for the whole life of a request and drops only when idle.
// - bit 3 is high while a write status request is active or responses are queued.
// - bit 2 is high while the request processing and submission logic works.
// - bit 1 is high while an enabled quick event is pending.
// - bit 0 is high while a latched-and-enabled, software-set or chained event is pending.
// - a per-channel register is 64 bits in low and high words, bit index equal to channel.
// - the per-channel enable register is read and written, the latch register only read, through the global range and each shadow.
// - shadow reads and writes touch only bits enabled for that region.
// - the count rises on submit with completion, falls on valid returns, and at 63 blocks new.
// - bits 16 and 17 show a request waiting in queue 0 and queue 1.
`timescale 1ns/1ps
module dma_controller_status_view
   import dma_status_pkg::*;
#(
   parameter int CHANNELS = NUM_CHANNELS,
   parameter int REGIONS  = NUM_REGIONS
) (
   // clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   // controller activity
   input  wire logic                 submit_with_completion,
   input  wire logic                 completion_code_valid,
   input  wire logic                 submit_busy,
   input  wire logic                 write_status_req,
   input  wire logic                 write_status_fifo_nonempty,
   input  wire logic [CHANNELS-1:0]  event_latch_register,
   input  wire logic [CHANNELS-1:0]  event_set_register,
   input  wire logic [CHANNELS-1:0]  chained_event_register,
   input  wire logic [7:0]           quick_event_latch,
   input  wire logic                 queue_zero_active,
   input  wire logic                 queue_one_active,
   // register access port
   input  wire reg_req_t             req,
   output logic      [31:0]          rdata,
   output logic                      rvalid,
   // status and flow
   output logic                      service_hold,
   output logic      [31:0]          controller_activity_status,
   output logic      [CHANNELS-1:0]  event_enable_register
);
   logic [COUNT_W-1:0]              count_q;
   logic [COUNT_W-1:0]              count_d;
   logic [CHANNELS-1:0]             enable_q;
   logic [REGIONS-1:0][63:0]        access_q;
   logic [7:0]                      quick_enable_q;
   logic [31:0]                     mask;
   logic [31:0]                     rdata_d;
   logic [31:0]                     status_d;
   logic                            hi_sel;
   logic                            submit_ok;
   logic                            any_evt;
   logic                            any_qevt;

   function automatic logic [31:0] merge_word(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [31:0] m);
      merge_word = (old_v & ~m) | (new_v & m);
   endfunction

   assign hi_sel    = (req.addr == ADDR_CHAN_HI) || (req.addr == ADDR_ENABLE_HI);
   assign submit_ok = submit_with_completion && (count_q != COUNT_MAX);
   assign any_evt   = |((event_latch_register & enable_q) | event_set_register
                       | chained_event_register);
   assign any_qevt  = |(quick_event_latch & quick_enable_q);

   region_access_filter #(
      .REGIONS   (REGIONS)
   ) u_filter (
      .shadow    (req.shadow),
      .region    (req.region),
      .high_half (hi_sel),
      .enables   (access_q),
      .mask      (mask)
   );

   // completion counter; a return in the same cycle as a submit cancels it, except at a count of zero where the submit counts
   always_comb begin
      count_d = count_q;
      if (submit_ok && !(completion_code_valid && count_q != '0)) begin
         count_d = count_q + 6'h01;
      end else if (!submit_ok && completion_code_valid && count_q != '0) begin
         count_d = count_q - 6'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end

   // hold is registered so the output comes straight from a flip-flop
   always_ff @(posedge core_clk) begin
      if (rst) begin
         service_hold <= 1'b0;
      end else begin
         service_hold <= (count_d == COUNT_MAX);
      end
   end

   // per-channel enable register, 64 bits across two words
   always_ff @(posedge core_clk) begin
      if (rst) begin
         enable_q <= '0;
      end else if (req.valid && req.write && req.addr == ADDR_ENABLE_LO) begin
         enable_q[31:0]  <= merge_word(enable_q[31:0], req.wdata, mask);
      end else if (req.valid && req.write && req.addr == ADDR_ENABLE_HI) begin
         enable_q[63:32] <= merge_word(enable_q[63:32], req.wdata, mask);
      end
   end

   // region access enables are global only: a shadow must not widen its own rights
   always_ff @(posedge core_clk) begin
      if (rst) begin
         access_q <= '0;
      end else if (req.valid && req.write && !req.shadow) begin
         if (req.addr == ADDR_ACCESS_LO) begin
            access_q[req.region][31:0]  <= req.wdata;
         end else if (req.addr == ADDR_ACCESS_HI) begin
            access_q[req.region][63:32] <= req.wdata;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         quick_enable_q <= '0;
      end else begin
         quick_enable_q <= 8'hff;
      end
   end

   always_comb begin
      status_d                 = STAT_RESET;
      status_d[STAT_EVT_BIT]   = any_evt;
      status_d[STAT_QEVT_BIT]  = any_qevt;
      status_d[STAT_TR_BIT]    = submit_busy;
      status_d[STAT_WSTAT_BIT] = write_status_req || write_status_fifo_nonempty;
      status_d[STAT_COUNT_LSB +: COUNT_W] = count_d;
      status_d[STAT_Q0_BIT]    = queue_zero_active;
      status_d[STAT_Q1_BIT]    = queue_one_active;
      status_d[STAT_CONTROLLER_ACTIVE_BIT]  = any_evt || any_qevt || submit_busy || write_status_req
                                 || write_status_fifo_nonempty || (count_d != '0)
                                 || queue_zero_active || queue_one_active;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         controller_activity_status <= STAT_RESET;
      end else begin
         controller_activity_status <= status_d;
      end
   end

   always_comb begin
      case (req.addr)
         ADDR_STATUS:    rdata_d = status_d;
         ADDR_CHAN_LO:   rdata_d = event_latch_register[31:0] & mask;
         ADDR_CHAN_HI:   rdata_d = event_latch_register[63:32] & mask;
         ADDR_ENABLE_LO: rdata_d = enable_q[31:0] & mask;
         ADDR_ENABLE_HI: rdata_d = enable_q[63:32] & mask;
         ADDR_ACCESS_LO: rdata_d = access_q[req.region][31:0];
         ADDR_ACCESS_HI: rdata_d = access_q[req.region][63:32];
         default:        rdata_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdata  <= '0;
         rvalid <= 1'b0;
      end else begin
         rvalid <= req.valid && !req.write;
         rdata  <= (req.valid && !req.write) ? rdata_d : 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         event_enable_register <= '0;
      end else begin
         event_enable_register <= enable_q;
      end
   end

   a_count_up: assert property (@(posedge core_clk) disable iff (rst)
      submit_ok && !completion_code_valid |=> count_q == $past(count_q) + 6'h01)
      else $error("count did not rise on submit");
   a_count_cap: assert property (@(posedge core_clk) disable iff (rst)
      count_q == COUNT_MAX && !completion_code_valid |=> count_q == COUNT_MAX)
      else $error("count passed its ceiling");
   a_active_or: assert property (@(posedge core_clk) disable iff (rst)
      controller_activity_status[STAT_CONTROLLER_ACTIVE_BIT] ==
      (|controller_activity_status[STAT_Q1_BIT:STAT_COUNT_LSB]
       || |controller_activity_status[STAT_WSTAT_BIT:STAT_EVT_BIT]))
      else $error("active bit not the or of others");
   a_active_hold: assert property (@(posedge core_clk) disable iff (rst)
      submit_busy |=> controller_activity_status[STAT_CONTROLLER_ACTIVE_BIT])
      else $error("active dropped during request");
   a_wstat_bit: assert property (@(posedge core_clk) disable iff (rst)
      write_status_fifo_nonempty |=> controller_activity_status[STAT_WSTAT_BIT])
      else $error("write status bit missing");
   a_tr_bit: assert property (@(posedge core_clk) disable iff (rst)
      1'b1 |=> controller_activity_status[STAT_TR_BIT] == $past(submit_busy))
      else $error("submit bit wrong");
   a_qevt_bit: assert property (@(posedge core_clk) disable iff (rst)
      1'b1 |=> controller_activity_status[STAT_QEVT_BIT] == $past(any_qevt))
      else $error("quick event bit wrong");
   a_evt_bit: assert property (@(posedge core_clk) disable iff (rst)
      |event_set_register |=> controller_activity_status[STAT_EVT_BIT])
      else $error("event bit missing");
   a_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
      controller_activity_status[31:18] == '0 && controller_activity_status[7:5] == '0)
      else $error("reserved bits nonzero");
   a_queue_bits: assert property (@(posedge core_clk) disable iff (rst)
      queue_one_active |=> controller_activity_status[STAT_Q1_BIT])
      else $error("queue one bit missing");
   a_shadow_read: assert property (@(posedge core_clk) disable iff (rst)
      req.valid && !req.write && req.shadow && req.addr == ADDR_ENABLE_LO
      |=> (rdata & ~$past(access_q[req.region][31:0])) == '0)
      else $error("shadow read leaked disabled bits");

   // counter bookkeeping
   a_count_down: assert property (@(posedge core_clk) disable iff (rst)
      !submit_with_completion && completion_code_valid && count_q != '0
      |=> count_q == $past(count_q) - 6'h01)
      else $error("count did not fall on return");
   a_count_both: assert property (@(posedge core_clk) disable iff (rst)
      submit_ok && completion_code_valid && count_q != '0
      |=> count_q == $past(count_q))
      else $error("submit and return did not cancel");
   a_count_floor: assert property (@(posedge core_clk) disable iff (rst)
      count_q == '0 && !submit_with_completion |=> count_q == '0)
      else $error("count fell below zero");
   a_hold_level: assert property (@(posedge core_clk) disable iff (rst)
      service_hold == (count_q == COUNT_MAX))
      else $error("hold does not follow ceiling");
   a_count_field: assert property (@(posedge core_clk) disable iff (rst)
      controller_activity_status[STAT_COUNT_LSB +: COUNT_W] == count_q)
      else $error("count field differs from counter");
   a_active_count: assert property (@(posedge core_clk) disable iff (rst)
      count_q != '0 |-> controller_activity_status[STAT_CONTROLLER_ACTIVE_BIT])
      else $error("active low with completions outstanding");

   // status bits against their sources
   a_wreq_bit: assert property (@(posedge core_clk) disable iff (rst)
      write_status_req |=> controller_activity_status[STAT_WSTAT_BIT])
      else $error("write status request not shown");
   a_wstat_idle: assert property (@(posedge core_clk) disable iff (rst)
      !write_status_req && !write_status_fifo_nonempty
      |=> !controller_activity_status[STAT_WSTAT_BIT])
      else $error("write status bit set while idle");
   a_evt_latch: assert property (@(posedge core_clk) disable iff (rst)
      |(event_latch_register & enable_q) |=> controller_activity_status[STAT_EVT_BIT])
      else $error("enabled latched event not shown");
   a_evt_chain: assert property (@(posedge core_clk) disable iff (rst)
      |chained_event_register |=> controller_activity_status[STAT_EVT_BIT])
      else $error("chained event not shown");
   a_evt_idle: assert property (@(posedge core_clk) disable iff (rst)
      !any_evt |=> !controller_activity_status[STAT_EVT_BIT])
      else $error("event bit set with nothing pending");
   a_queue_zero: assert property (@(posedge core_clk) disable iff (rst)
      queue_zero_active |=> controller_activity_status[STAT_Q0_BIT])
      else $error("queue zero bit missing");
   a_queue_idle: assert property (@(posedge core_clk) disable iff (rst)
      !queue_zero_active && !queue_one_active
      |=> controller_activity_status[STAT_Q1_BIT:STAT_Q0_BIT] == '0)
      else $error("queue bits set while queues empty");
   a_reserved_mid: assert property (@(posedge core_clk) disable iff (rst)
      controller_activity_status[15:14] == '0)
      else $error("reserved middle bits nonzero");

   // register access port
   a_rvalid_read: assert property (@(posedge core_clk) disable iff (rst)
      req.valid && !req.write |=> rvalid)
      else $error("read not answered");
   a_rvalid_write: assert property (@(posedge core_clk) disable iff (rst)
      !(req.valid && !req.write) |=> !rvalid && rdata == '0)
      else $error("read answer without a read");
   a_status_read: assert property (@(posedge core_clk) disable iff (rst)
      req.valid && !req.write && req.addr == ADDR_STATUS
      |=> rdata == controller_activity_status)
      else $error("status read differs from status");
   a_global_read: assert property (@(posedge core_clk) disable iff (rst)
      req.valid && !req.write && !req.shadow && req.addr == ADDR_ENABLE_HI
      |=> rdata == $past(enable_q[63:32]))
      else $error("global read not the full word");
   a_shadow_write: assert property (@(posedge core_clk) disable iff (rst)
      req.valid && req.write && req.shadow && req.addr == ADDR_ENABLE_LO
      |=> ((enable_q[31:0] ^ $past(enable_q[31:0])) & ~$past(access_q[req.region][31:0])) == '0)
      else $error("shadow write changed disabled bits");
   a_access_shadow: assert property (@(posedge core_clk) disable iff (rst)
      req.valid && req.write && req.shadow |=> access_q == $past(access_q))
      else $error("shadow write changed access enables");
   a_enable_copy: assert property (@(posedge core_clk) disable iff (rst)
      1'b1 |=> event_enable_register == $past(enable_q))
      else $error("enable output differs from register");
   a_shadow_latch: assert property (@(posedge core_clk) disable iff (rst)
      req.valid && !req.write && req.shadow && req.addr == ADDR_CHAN_HI
      |=> (rdata & ~$past(access_q[req.region][63:32])) == '0)
      else $error("shadow latch read leaked disabled bits");
   a_unmapped_read: assert property (@(posedge core_clk) disable iff (rst)
      req.valid && !req.write && req.addr > ADDR_ACCESS_HI |=> rdata == '0)
      else $error("unmapped read not zero");
endmodule // dma_controller_status_view

// ---- rtl/dma_status_pkg.sv ----
// package: status register layout, per-channel register geometry and shadow access codes
// assumes: shared by the status view top and its region access filter
package dma_status_pkg;
   localparam int          NUM_CHANNELS     = 64;
   localparam int          WORD_W           = 32;
   localparam int          NUM_REGIONS      = 4;
   localparam int          COUNT_W          = 6;
   localparam logic [5:0]  COUNT_MAX        = 6'h3f;
   localparam int          STAT_EVT_BIT     = 0;
   localparam int          STAT_QEVT_BIT    = 1;
   localparam int          STAT_TR_BIT      = 2;
   localparam int          STAT_WSTAT_BIT   = 3;
   localparam int          STAT_CONTROLLER_ACTIVE_BIT    = 4;
   localparam int          STAT_COUNT_LSB   = 8;
   localparam int          STAT_Q0_BIT      = 16;
   localparam int          STAT_Q1_BIT      = 17;
   localparam logic [31:0] STAT_RESET       = 32'h0000_0000;
   // register address selects (index into the access port)
   localparam logic [3:0]  ADDR_STATUS      = 4'h0;
   localparam logic [3:0]  ADDR_CHAN_LO     = 4'h1;
   localparam logic [3:0]  ADDR_CHAN_HI     = 4'h2;
   localparam logic [3:0]  ADDR_ENABLE_LO   = 4'h3;
   localparam logic [3:0]  ADDR_ENABLE_HI   = 4'h4;
   localparam logic [3:0]  ADDR_ACCESS_LO   = 4'h5;
   localparam logic [3:0]  ADDR_ACCESS_HI   = 4'h6;

   typedef struct packed {
      logic        evt;
      logic        qevt;
      logic        tr;
      logic        wstat;
      logic        controller_active;
      logic [5:0]  count;
      logic        q0;
      logic        q1;
   } activity_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic        shadow;
      logic [1:0]  region;
      logic [3:0]  addr;
      logic [31:0] wdata;
   } reg_req_t;
endpackage

// ---- rtl/region_access_filter.sv ----
// region access filter: masks per-channel word access for a shadow region
// assumes: region enable words are held by the caller, global access passes unfiltered
`timescale 1ns/1ps
module region_access_filter
   import dma_status_pkg::*;
#(
   parameter int REGIONS = NUM_REGIONS
) (
   // access
   input  wire logic                       shadow,
   input  wire logic [1:0]                 region,
   input  wire logic                       high_half,
   input  wire logic [REGIONS-1:0][63:0]   enables,
   // result
   output logic      [31:0]                mask
);
   logic [63:0] sel;

   always_comb begin
      sel  = enables[region];
      // global range sees every channel, shadow only enabled ones
      if (!shadow) begin
         mask = 32'hffff_ffff;
      end else if (high_half) begin
         mask = sel[63:32];
      end else begin
         mask = sel[31:0];
      end
   end
endmodule // region_access_filter

// ---- tb/tb_top.sv ----
// testbench: status view scenarios, register access and completion counting
// assumes: design answers reads one cycle after the request, status follows in one cycle
`timescale 1ns/1ps
module tb_top;
   import dma_status_pkg::*;
   logic        core_clk, rst, sub, sbusy, wreq, wfifo, q0, q1, cv, start, pbusy;
   logic        rvalid, hold;
   logic [63:0] evl, evs, evc, een;
   logic [7:0]  qel;
   logic [6:0]  n_ret;
   logic [3:0]  gap;
   logic [31:0] rdata, stat;
   reg_req_t    req;
   int          n_fail, num_checks, cyc, i;
   localparam logic [31:0] ACT = 32'h1 << STAT_CONTROLLER_ACTIVE_BIT;

   dma_controller_status_view u_dut (.core_clk(core_clk), .rst(rst),
      .submit_with_completion(sub), .completion_code_valid(cv), .submit_busy(sbusy),
      .write_status_req(wreq), .write_status_fifo_nonempty(wfifo),
      .event_latch_register(evl), .event_set_register(evs), .chained_event_register(evc),
      .quick_event_latch(qel), .queue_zero_active(q0), .queue_one_active(q1), .req(req),
      .rdata(rdata), .rvalid(rvalid), .service_hold(hold),
      .controller_activity_status(stat), .event_enable_register(een));
   tc_return_model u_tc (.core_clk(core_clk), .rst(rst), .start(start), .n_ret(n_ret),
      .gap(gap), .completion_code_valid(cv), .busy(pbusy));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic give_verdict();
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         give_verdict();
      end
   end

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // one-cycle request; read data is settled when this returns
   task automatic access(input logic wr, input logic sh, input logic [1:0] rg,
                         input logic [3:0] a, input logic [31:0] d);
      tick(1);
      req = '{valid: 1'b1, write: wr, shadow: sh, region: rg, addr: a, wdata: d};
      tick(1);
      req.valid = 1'b0;
   endtask

   task automatic tc_return(input logic [6:0] n, input logic [3:0] g);
      n_ret = n;
      gap   = g;
      start = 1'b1;
      tick(1);
      start = 1'b0;
      for (int k = 0; k < 400 && pbusy; k++) tick(1);
      tick(2);
   endtask

   task automatic t_reset();
      chk("status after reset", 32'h0, stat);
      access(1'b1, 1'b0, 2'h0, ADDR_STATUS, 32'hffff_ffff);
      access(1'b0, 1'b0, 2'h0, ADDR_STATUS, 32'h0);
      chk("status read", 32'h0, rdata);
      chk("read valid", 1'b1, rvalid);
      access(1'b0, 1'b0, 2'h0, 4'hf, 32'h0);
      chk("unmapped read", 32'h0, rdata);
   endtask

   task automatic t_activity();
      for (i = 0; i < 7; i++) begin
         {sbusy, wreq, wfifo, q0, q1} = 5'h0;
         qel = 8'h0;
         case (i)
            0: sbusy = 1'b1;
            1: wreq  = 1'b1;
            2: wfifo = 1'b1;
            3: qel   = 8'h80;
            4: q0    = 1'b1;
            5: q1    = 1'b1;
            default: ;
         endcase
         tick(2);
         case (i)
            0: chk("submit active", ACT | (32'h1 << STAT_TR_BIT), stat);
            1, 2: chk("write status active", ACT | (32'h1 << STAT_WSTAT_BIT), stat);
            3: chk("quick event active", ACT | (32'h1 << STAT_QEVT_BIT), stat);
            4: chk("queue zero active", ACT | (32'h1 << STAT_Q0_BIT), stat);
            5: chk("queue one active", ACT | (32'h1 << STAT_Q1_BIT), stat);
            default: chk("all idle", 32'h0, stat);
         endcase
      end
   endtask

   task automatic t_events();
      access(1'b1, 1'b0, 2'h0, ADDR_ENABLE_LO, 32'h0000_0020);
      evl = 64'h40;
      tick(2);
      chk("latched not enabled", 32'h0, stat);
      evl = 64'h20;
      tick(2);
      chk("latched and enabled", ACT | 32'h1, stat);
      evl = 64'h0;
      evs = 64'h8000_0000_0000_0000;
      tick(2);
      chk("software set", ACT | 32'h1, stat);
      evs = 64'h0;
      evc = 64'h1;
      tick(2);
      chk("chained", ACT | 32'h1, stat);
      evc = 64'h0;
   endtask

   task automatic t_regs();
      access(1'b1, 1'b0, 2'h0, ADDR_ENABLE_HI, 32'ha5a5_0f0f);
      access(1'b0, 1'b0, 2'h0, ADDR_ENABLE_HI, 32'h0);
      chk("enable high word", 32'ha5a5_0f0f, rdata);
      chk("enable bits", 64'ha5a5_0f0f_0000_0020, een);
      access(1'b1, 1'b0, 2'h1, ADDR_ACCESS_LO, 32'h0000_ffff);
      access(1'b1, 1'b1, 2'h1, ADDR_ENABLE_LO, 32'hffff_ffff);
      access(1'b0, 1'b0, 2'h0, ADDR_ENABLE_LO, 32'h0);
      chk("shadow write masked", 32'h0000_ffff, rdata);
      access(1'b0, 1'b1, 2'h1, ADDR_ENABLE_HI, 32'h0);
      chk("shadow read masked", 32'h0, rdata);
      access(1'b0, 1'b1, 2'h2, ADDR_ENABLE_LO, 32'h0);
      chk("other region read", 32'h0, rdata);
      access(1'b1, 1'b1, 2'h1, ADDR_ACCESS_LO, 32'hffff_ffff);
      access(1'b0, 1'b0, 2'h1, ADDR_ACCESS_LO, 32'h0);
      chk("access word kept", 32'h0000_ffff, rdata);
      evl = 64'h8000_0001_0001_0104;
      access(1'b0, 1'b0, 2'h0, ADDR_CHAN_HI, 32'h0);
      chk("latch high word", 32'h8000_0001, rdata);
      access(1'b0, 1'b1, 2'h1, ADDR_CHAN_LO, 32'h0);
      chk("latch low word shadow", 32'h0000_0104, rdata);
      evl = 64'h0;
   endtask

   task automatic t_count();
      sub = 1'b1;
      tick(1);
      sub = 1'b0;
      tick(2);
      chk("one outstanding", ACT | (32'h1 << STAT_COUNT_LSB), stat);
      access(1'b0, 1'b0, 2'h0, ADDR_STATUS, 32'h0);
      chk("status read busy", ACT | (32'h1 << STAT_COUNT_LSB), rdata);
      sub = 1'b1;
      tick(70);
      sub = 1'b0;
      tick(2);
      chk("count at ceiling", ACT | (32'h3f << STAT_COUNT_LSB), stat);
      chk("hold at ceiling", 1'b1, hold);
      tc_return(7'h3, 4'h3);
      chk("count after slow returns", ACT | (32'h3c << STAT_COUNT_LSB), stat);
      chk("hold released", 1'b0, hold);
      tc_return(7'h3c, 4'h0);
      chk("idle after all returned", 32'h0, stat);
   endtask

   initial begin
      {rst, sub, sbusy, wreq, wfifo, q0, q1, start} = 8'h80;
      {evl, evs, evc} = '0;
      qel = 8'h0;
      n_ret = 7'h0;
      gap = 4'h0;
      req = '0;
      repeat (8) @(posedge core_clk);
      #1;
      rst = 1'b0;
      t_reset();
      t_activity();
      t_events();
      t_regs();
      t_count();
      give_verdict();
   end
endmodule // tb_top

// ---- tb/tc_return_model.sv ----
// transfer controller model: hands back completion codes after a command
// assumes: bench pulses start for one cycle; gap sets idle cycles between returns
`timescale 1ns/1ps
module tc_return_model (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   // command
   input  wire logic       start,
   input  wire logic [6:0] n_ret,
   input  wire logic [3:0] gap,
   // returns
   output logic            completion_code_valid,
   output logic            busy
);
   logic [6:0] left_q;
   logic [3:0] wait_q;

   always_ff @(posedge core_clk) begin
      if (rst || start) begin
         left_q                <= rst ? 7'h0 : n_ret;
         wait_q                <= gap;
         completion_code_valid <= 1'b0;
      end else if (left_q != 7'h0 && wait_q == 4'h0) begin
         // one code per pulse, never more than were asked for
         completion_code_valid <= 1'b1;
         left_q                <= left_q - 7'h1;
         wait_q                <= gap;
      end else begin
         completion_code_valid <= 1'b0;
         wait_q                <= (left_q != 7'h0) ? wait_q - 4'h1 : wait_q;
      end
   end

   assign busy = (left_q != 7'h0) || completion_code_valid;
endmodule // tc_return_model
